// [fsr_regs.svh]
// register field positions, command codes and timing counts for the host
`ifndef FSR_REGS_SVH
`define FSR_REGS_SVH

`define FSR_SR_READY        7
`define FSR_SR_ERASE_SUSP   6
`define FSR_SR_ERASE_ERR    5
`define FSR_SR_PROG_ERR     4
`define FSR_SR_SUPPLY_LOW   3
`define FSR_SR_PROG_SUSP    2
`define FSR_SR_PROTECT_ERR  1
`define FSR_SR_VALID_MASK   8'hFE
`define FSR_XSR_BUF_AVAIL   7
`define FSR_XSR_VALID_MASK  8'h80
`define FSR_CMD_READ_STATUS 8'h70
`define FSR_CMD_CLEAR_STAT  8'h50
`define FSR_CMD_CONFIG      8'hB8
`define FSR_CMD_WRBUF       8'hE8
`define FSR_CLK_NS          50
`define FSR_PULSE_NS        250
// shortest low time accepted as a completion pulse: half the typical width
`define FSR_PULSE_MIN_CYC   (((`FSR_PULSE_NS / 2) + `FSR_CLK_NS - 1) / `FSR_CLK_NS)
`define FSR_STROBE_CYC      3'h3
`define FSR_READ_WAIT_CYC   3'h4

`endif

// [fsr_pkg.sv]
// types shared by the flash status host controller
package fsr_pkg;

    typedef enum logic [1:0] {
        FSR_CFG_LEVEL,
        FSR_CFG_ERASE,
        FSR_CFG_PROG,
        FSR_CFG_BOTH
    } fsr_cfg_t;

    typedef struct packed {
        logic       ready;
        logic       erase_suspended;
        logic       erase_clear_error;
        logic       program_setlock_error;
        logic       supply_low;
        logic       program_suspended;
        logic       protect_error;
        logic       sequence_error;
    } fsr_status_t;

    typedef struct packed {
        logic       chip_select_n;
        logic       write_n;
        logic       read_n;
        logic       reset_powerdown_n;
    } fsr_ctrl_t;

endpackage

// [fsr_host.sv]
// host controller that writes flash commands and reads back status
//
// Function
// RL1 - pulse modes: a low pulse of about 250 ns marks completion
// RL2 - status bit 7 is ready when 1, busy when 0
// RL3 - host ignores status bits 6 to 0 until bit 7 reads 1
// RL4 - status bit 6 set while block erase is suspended
// RL5 - status bit 5 set on erase or clear-lock failure
// RL6 - bits 5 and 4 both set flag a malformed command sequence
// RL7 - status bit 4 set on program or set-lock failure
// RL8 - status bit 3 reports low programming supply after an operation
// RL9 - status bit 2 set while programming is suspended
// RL10 - status bit 1 set when a lock aborted the operation
// RL11 - host masks reserved status bit 0 when polling
// RL12 - extended bit 7 tells whether another buffered write fits
// RL13 - host masks extended bits 6 to 0 when polling
// RL14 - status pin is open drain, host supplies the pull-up
// RL15 - level mode: pin low while the sequencer is busy
// RL16 - level mode: pin high in erase suspend and in reset
// RL17 - supply error sets bit 3 with bit 4 or bit 5
// RL18 - reset during an operation aborts it; pin stays low meanwhile
// RL19 - host reissues the full sequence after an aborted operation; the controller only raises abort_seen and the user reissues it
// RL20 - command write only with write strobe and chip select both low
// RL21 - while reset-powerdown is low the device ignores other inputs
// RL22 - two-bit code selects level or pulse behaviour of the pin
`timescale 1ns/100ps
`include "fsr_regs.svh"
module fsr_host
    import fsr_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    // user command port
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic [7:0]  cmd_code,
    input  wire logic [7:0]  cmd_data,
    input  wire logic        cmd_two_cycle,
    input  wire logic        poll_status,
    input  wire logic        poll_ext,
    input  wire logic [1:0]  cfg_mode,
    input  wire logic        powerdown_req,
    // user status results
    output logic             busy,
    output logic             done_pulse,
    output fsr_status_t      status,
    output logic             status_valid,
    output logic             buf_avail,
    output logic             seq_error,
    output logic             supply_error,
    output logic             abort_seen,
    // device pins
    output fsr_ctrl_t        dev_ctrl,
    output logic [7:0]       dq_o,
    output logic             dq_oe,
    input  wire logic [7:0]  dq_i,
    input  wire logic        completion_pin_i
);

    typedef enum logic [2:0] {
        ST_IDLE, ST_SETUP, ST_GAP, ST_SECOND, ST_READCMD, ST_READ
    } fsr_state_t;

    fsr_state_t  state_q, state_d;
    logic [2:0]  cnt_q;
    logic [7:0]  code_q, data_q;
    logic        two_q, ext_q, write_phase;
    logic [7:0]  dq_sync1_q, dq_sync2_q;
    logic        pin_sync1_q, pin_sync2_q, pin_prev_q;
    logic [2:0]  low_cnt_q;
    logic        pd_q, was_busy_q;
    logic [7:0]  sr_q;
    logic        sv_q, buf_q, abort_q, done_q;
    fsr_cfg_t    cfg;

    // pin and data bus double synchronisers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            dq_sync1_q  <= 8'h00;
            dq_sync2_q  <= 8'h00;
            pin_sync1_q <= 1'b1;
            pin_sync2_q <= 1'b1;
            pin_prev_q  <= 1'b1;
        end else begin
            dq_sync1_q  <= dq_i;
            dq_sync2_q  <= dq_sync1_q;
            pin_sync1_q <= completion_pin_i;
            pin_sync2_q <= pin_sync1_q;
            pin_prev_q  <= pin_sync2_q;
        end
    end

    // pin interpretation per configuration code
    assign cfg        = fsr_cfg_t'(cfg_mode); // RL22
    wire pin_low      = !pin_sync2_q; // RL14
    wire pin_rise     = pin_sync2_q && !pin_prev_q;
    // short glitches are not taken as completion pulses
    wire pulse_ok     = low_cnt_q >= 3'(`FSR_PULSE_MIN_CYC); // RL1
    wire pulse_done   = (cfg != FSR_CFG_LEVEL) && pin_rise && pulse_ok; // RL1
    wire level_busy   = (cfg == FSR_CFG_LEVEL) && pin_low; // RL15 RL16
    wire level_done   = (cfg == FSR_CFG_LEVEL) && pin_rise;

    // low-time counter for pulse qualification, saturating
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) low_cnt_q <= 3'h0;
        else if (!pin_low) low_cnt_q <= 3'h0;
        else if (low_cnt_q != 3'h7) low_cnt_q <= low_cnt_q + 3'h1;
    end

    // command sequencer; reads wait while the device is in power-down
    wire in_pd      = pd_q; // RL21
    assign cmd_ready = (state_q == ST_IDLE) && !in_pd;
    wire take_cmd   = cmd_valid && cmd_ready;
    wire take_poll  = (poll_status || poll_ext) && cmd_ready && !cmd_valid;
    wire cnt_done   = (cnt_q == 3'h0);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE:    if (take_cmd) state_d = ST_SETUP;
                        else if (take_poll) state_d = ST_READCMD;
            ST_SETUP:   if (cnt_done) state_d = two_q ? ST_GAP : ST_IDLE;
            ST_GAP:     state_d = ST_SECOND;
            ST_SECOND:  if (cnt_done) state_d = ST_IDLE;
            ST_READCMD: if (cnt_done) state_d = ST_READ;
            ST_READ:    if (cnt_done) state_d = ST_IDLE;
            default:    state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ST_IDLE;
            cnt_q   <= 3'h0;
            code_q  <= 8'h00;
            data_q  <= 8'h00;
            two_q   <= 1'b0;
            ext_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            if (state_d != state_q)
                cnt_q <= (state_d == ST_READ) ? `FSR_READ_WAIT_CYC
                                              : `FSR_STROBE_CYC;
            else if (!cnt_done)
                cnt_q <= cnt_q - 3'h1;
            if (take_cmd) begin
                code_q <= cmd_code;
                data_q <= cmd_data;
                two_q  <= cmd_two_cycle;
            end
            if (take_poll) ext_q <= poll_ext && !poll_status;
        end
    end

    // write strobe and chip select low together only for a write
    assign write_phase = (state_q == ST_SETUP) || (state_q == ST_SECOND)
                      || (state_q == ST_READCMD);
    wire read_phase   = (state_q == ST_READ);
    // extended status only comes back behind a buffered-write setup
    wire [7:0] rd_cmd  = ext_q ? `FSR_CMD_WRBUF : `FSR_CMD_READ_STATUS;
    wire [7:0] wr_byte = (state_q == ST_SECOND) ? data_q :
                         (state_q == ST_READCMD) ? rd_cmd : // RL13
                         code_q;

    // pin outputs registered; data bus driven only during writes
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            dev_ctrl <= '{1'b1, 1'b1, 1'b1, 1'b0};
            dq_o     <= 8'h00;
            dq_oe    <= 1'b0;
        end else begin
            dev_ctrl.chip_select_n     <= !(write_phase || read_phase); // RL20
            dev_ctrl.write_n           <= !(write_phase && !cnt_done); // RL20
            dev_ctrl.read_n            <= !read_phase;
            dev_ctrl.reset_powerdown_n <= !powerdown_req; // RL21
            dq_o                       <= wr_byte;
            dq_oe                      <= write_phase;
        end
    end

    // status capture; reserved bits masked as they arrive
    wire capture   = read_phase && cnt_done;
    wire [7:0] rd  = dq_sync2_q & (ext_q ? `FSR_XSR_VALID_MASK
                                         : `FSR_SR_VALID_MASK); // RL11 RL13
    wire rd_ready  = rd[`FSR_SR_READY]; // RL2
    wire op_start  = take_cmd && (cmd_code != `FSR_CMD_CLEAR_STAT)
                     && (cmd_code != `FSR_CMD_CONFIG);

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sr_q       <= 8'h00;
            sv_q       <= 1'b0;
            buf_q      <= 1'b0;
            pd_q       <= 1'b1;
            was_busy_q <= 1'b0;
            abort_q    <= 1'b0;
            done_q     <= 1'b0;
        end else begin
            pd_q   <= powerdown_req;
            done_q <= pulse_done || level_done;
            // an operation cut by reset must be reissued by the user
            if (powerdown_req && (was_busy_q || level_busy))
                abort_q <= 1'b1; // RL18 RL19
            else if (op_start)
                abort_q <= 1'b0;
            if (op_start)
                was_busy_q <= 1'b1;
            else if (done_q || (capture && !ext_q && rd_ready)
                     || powerdown_req)
                was_busy_q <= 1'b0;
            if (op_start || powerdown_req)
                sv_q <= 1'b0;
            if (capture && ext_q)
                buf_q <= rd[`FSR_XSR_BUF_AVAIL]; // RL12
            else if (take_cmd && cmd_code == `FSR_CMD_WRBUF)
                buf_q <= 1'b0;
            if (capture && !ext_q) begin
                // low bits only trusted once ready reads 1
                sr_q <= rd_ready ? rd : 8'h00; // RL3
                sv_q <= rd_ready; // RL3
            end
        end
    end

    // decoded status view
    assign status = fsr_status_t'(sr_q); // RL4 RL5 RL7 RL9 RL10
    assign status_valid = sv_q;
    assign buf_avail    = buf_q;
    assign seq_error    = sv_q && sr_q[`FSR_SR_ERASE_ERR]
                               && sr_q[`FSR_SR_PROG_ERR]; // RL6
    assign supply_error = sv_q && sr_q[`FSR_SR_SUPPLY_LOW]; // RL8 RL17
    assign abort_seen   = abort_q;
    assign busy         = level_busy || was_busy_q;
    assign done_pulse   = done_q;

endmodule // fsr_host

// [fsr_flash_model.sv]
// behavioural flash device facing the host pins
`timescale 1ns/100ps
module fsr_flash_model
    import fsr_pkg::*;
(
    // host pins
    input  wire fsr_ctrl_t   ctrl,
    input  wire logic [7:0]  dq_o,
    output logic [7:0]       dq_i,
    output wire              pin,
    // bench controls
    input  wire logic [7:0]  sr,
    input  wire logic        xbuf,
    input  wire logic        busy_in,
    input  wire logic        pulse_go
);
    logic [7:0] cmd_q = 8'h00;
    logic [1:0] mode_q = 2'h0;
    logic       pulse_q = 1'b0;
    wire        rp = ctrl.reset_powerdown_n;
    wire  [7:0] val = (cmd_q == 8'h70) ? sr : {xbuf, 7'h2A};
    // commands latch on the rising strobe, never in powerdown
    always @(posedge ctrl.write_n) begin
        if (!ctrl.chip_select_n && rp) begin
            if (cmd_q == 8'hB8)
                mode_q <= dq_o[1:0];
            cmd_q <= dq_o;
        end
    end
    // released bus shows the inverse so stale data cannot pass
    assign dq_i = (!ctrl.chip_select_n && !ctrl.read_n && rp) ? val : ~val;
    // completion pulse, only in pulse modes
    always @(posedge pulse_go) begin
        pulse_q = (mode_q != 2'h0);
        #250 pulse_q = 1'b0;
    end
    // open drain: level mode stays low through a reset that hits an op
    assign pin = ((mode_q == 2'h0 && busy_in) || (rp && pulse_q)) ? 1'b0
                 : 1'b1;
endmodule // fsr_flash_model

// [fsr_host_chk.sv]
// port assertions for the flash status host
`timescale 1ns/100ps
module fsr_host_chk
    import fsr_pkg::*;
(
    // clock and reset
    input wire logic        core_clk,
    input wire logic        rst_b,
    // watched ports
    input wire logic        cmd_valid,
    input wire logic        cmd_ready,
    input wire logic        powerdown_req,
    input wire logic        done_pulse,
    input wire logic        status_valid,
    input wire logic        dq_oe,
    input wire fsr_status_t status,
    input wire fsr_ctrl_t   dev_ctrl
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // strobe lengths of one write and one read
    sequence s_we; !dev_ctrl.write_n [*3] ##1 dev_ctrl.write_n; endsequence
    sequence s_rd; !dev_ctrl.read_n [*5] ##1 dev_ctrl.read_n; endsequence
    a_write_select: assert property (!dev_ctrl.write_n |->
        !dev_ctrl.chip_select_n) else $error("write without select");
    a_write_len: assert property ($fell(dev_ctrl.write_n) |-> s_we)
        else $error("write strobe length");
    a_read_len: assert property ($fell(dev_ctrl.read_n) |-> s_rd)
        else $error("read strobe length");
    a_read_release: assert property (!dev_ctrl.read_n |-> !dq_oe)
        else $error("bus driven during read");
    a_pd_follow: assert property (powerdown_req |=>
        !dev_ctrl.reset_powerdown_n) else $error("powerdown not driven");
    a_pd_idle: assert property (!dev_ctrl.reset_powerdown_n |->
        !cmd_ready) else $error("ready in powerdown");
    a_busy_zero: assert property (!status.ready |-> status == 8'h00)
        else $error("busy status not cleared");
    a_valid_ready: assert property (status_valid |->
        status.ready && !status.sequence_error) else $error("bad valid");
    a_take_drop: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
        else $error("ready held after take");
    a_done_once: assert property (done_pulse |=> !done_pulse)
        else $error("done longer than a cycle");
endmodule // fsr_host_chk
bind fsr_host fsr_host_chk i_fsr_host_chk (.core_clk, .rst_b, .cmd_valid,
    .cmd_ready, .powerdown_req, .done_pulse, .status_valid, .dq_oe,
    .status, .dev_ctrl);

// [test_fsr_host.sv]
// self-checking bench for the flash status host
`timescale 1ns/100ps
module test_fsr_host
    import fsr_pkg::*;
;
    logic        core_clk = 1'b0, rst_b = 1'b0, cmd_valid = 1'b0;
    logic        poll_status = 1'b0, poll_ext = 1'b0, cmd_two_cycle = 1'b0;
    logic        powerdown_req = 1'b0, xbuf = 1'b0, busy_in = 1'b0;
    logic        pulse_go = 1'b0, cmd_ready, busy, done_pulse, dq_oe;
    logic        status_valid, buf_avail, seq_error, supply_error;
    logic        abort_seen;
    logic [7:0]  cmd_code = 8'h00, cmd_data = 8'h00, sr = 8'h80;
    logic [7:0]  dq_o, dq_i;
    logic [1:0]  cfg_mode = 2'h0;
    wire         pin;
    fsr_status_t status;
    fsr_ctrl_t   dev_ctrl;
    int          error_cnt = 0, total_checks = 0;
    // sr value, expected status, expected {valid, seq, supply}
    logic [23:0] tbl [5] = '{24'hFFFE07, 24'hB0B006, 24'hC8C805,
                             24'hA6A604, 24'h7F0000};
    fsr_host i_fsr_host (.core_clk, .rst_b, .cmd_valid, .cmd_ready,
        .cmd_code, .cmd_data, .cmd_two_cycle, .poll_status, .poll_ext,
        .cfg_mode, .powerdown_req, .busy, .done_pulse, .status,
        .status_valid, .buf_avail, .seq_error, .supply_error, .abort_seen,
        .dev_ctrl, .dq_o, .dq_oe, .dq_i, .completion_pin_i(pin));
    fsr_flash_model i_fsr_flash_model (.ctrl(dev_ctrl), .dq_o, .dq_i, .pin,
        .sr, .xbuf, .busy_in, .pulse_go);
    initial forever #25 core_clk = ~core_clk;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        if (error_cnt == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // bounded wait for a flag, sampled at falling edges
    task automatic wait_for(ref logic f);
        for (int n = 0; n < 40 && f !== 1'b1; n++)
            @(negedge core_clk);
        chk(8'(f), 8'h01);
    endtask
    // one request; a poll when ps or pe is set
    task automatic req(input logic [7:0] c, d, input logic two, ps, pe);
        wait_for(cmd_ready);
        {cmd_code, cmd_data, cmd_two_cycle} = {c, d, two};
        {poll_status, poll_ext, cmd_valid} = {ps, pe, !(ps || pe)};
        @(negedge core_clk);
        {cmd_valid, poll_status, poll_ext} = 3'h0;
        @(negedge core_clk);
        wait_for(cmd_ready);
        @(negedge core_clk);
    endtask
    // watchdog: the whole sequence needs well under 2000 cycles
    initial begin
        #100000;
        error_cnt++;
        give_verdict;
    end
    initial begin
        repeat (6) @(negedge core_clk);
        chk(8'(dev_ctrl), 8'h0E);
        rst_b = 1'b1;
        for (int m = 3; m >= 0; m--) begin
            req(8'hB8, 8'(m), 1'b1, 1'b0, 1'b0);
            chk(8'(i_fsr_flash_model.mode_q), 8'(m));
        end
        foreach (tbl[i]) begin
            sr = tbl[i][23:16];
            req(8'h70, 8'h00, 1'b0, 1'b1, 1'b0);
            chk(status, tbl[i][15:8]);
            chk(8'({status_valid, seq_error, supply_error}),
                tbl[i][7:0]);
        end
        xbuf = 1'b1;
        req(8'h00, 8'h00, 1'b0, 1'b0, 1'b1);
        chk(8'(buf_avail), 8'h01);
        req(8'hE8, 8'h00, 1'b0, 1'b0, 1'b0);
        chk(8'(buf_avail), 8'h00);
        busy_in = 1'b1;
        repeat (4) @(negedge core_clk);
        chk(8'(busy), 8'h01);
        busy_in = 1'b0;
        wait_for(done_pulse);
        // every pulse code, so none of them goes untried
        for (int m = 1; m <= 3; m++) begin
            req(8'hB8, 8'(m), 1'b1, 1'b0, 1'b0);
            cfg_mode = 2'(m);
            pulse_go = 1'b1;
            wait_for(done_pulse);
            pulse_go = 1'b0;
        end
        req(8'hB8, 8'h00, 1'b1, 1'b0, 1'b0);
        cfg_mode = 2'h0;
        busy_in = 1'b1;
        repeat (4) @(negedge core_clk);
        powerdown_req = 1'b1;
        repeat (3) @(negedge core_clk);
        chk(8'({dev_ctrl.reset_powerdown_n, cmd_ready}), 8'h00);
        busy_in = 1'b0;
        powerdown_req = 1'b0;
        chk(8'(abort_seen), 8'h01);
        wait_for(cmd_ready);
        give_verdict;
    end
endmodule // test_fsr_host
